// ### hdl/cdef_defs.svh
// Offsets, field positions and reset values of the debug error flag bank
// Function
// [RL1] Upper-port abnormality sets protocol error, tags forwarding
// [RL2] Any other upper-port flag also sets protocol error
// [RL3] Unclassified abnormalities may set protocol error
// [RL4] Protocol error clear means no tag inserted
// [RL5] Incoming tagged frame sets incoming-tag flag
// [RL6] Timing locked but data lost sets second sync
// [RL7] Missing preamble or sync bit sets first sync
// [RL8] Too few agreeing samples sets weak-bit flag
// [RL9] Clear or start during transmit sets transmit-start error
// [RL10] Response CRC or byte error flagged, frame discarded
`ifndef CDEF_DEFS_SVH
`define CDEF_DEFS_SVH

// Register indices; byte address is four times the index
`define CDEF_IDX_UART 12'h782
`define CDEF_IDX_UPPER 12'h783
`define CDEF_IDX_INT_STAT 12'h790
`define CDEF_IDX_INT_MASK 12'h791
`define CDEF_IDX_CLEAR 12'h792

// Serial port flag positions
`define CDEF_UART_TRANSMIT_FRAME_START_ERROR 4
`define CDEF_UART_TRANSMIT_ABORT_WAIT_FLAG 3
`define CDEF_UART_RESPONSE_FRAME_START_ERROR 2
`define CDEF_UART_RR_BYTE 1
`define CDEF_UART_RESPONSE_CRC_ERROR 0

// Upper-port flag positions
`define CDEF_UP_PROTOCOL_ERROR_FLAG 4
`define CDEF_UP_TAG 3
`define CDEF_UP_SECOND_SYNC_ERROR_FLAG 2
`define CDEF_UP_FIRST_SYNC_ERROR_FLAG 1
`define CDEF_UP_WEAK 0

// Interrupt status and mask positions
`define CDEF_INT_UART 0
`define CDEF_INT_UPPER 1

// Clear register field base positions
`define CDEF_CLR_UART_LSB 0
`define CDEF_CLR_UPPER_LSB 8

// Reset values
`define CDEF_FLAGS_RST 5'h00
`define CDEF_INT_RST 2'h0

`endif

// ### hdl/cdef_pkg.sv
// Types shared by the debug error flag bank
package cdef_pkg;

	// Upper-port frame tracker, Gray coded from idle through sync to data
	typedef enum logic [1:0] {
		CDEF_IDLE = 2'b00, // Waiting for a frame
		CDEF_SYNC = 2'b01, // Looking for preamble and sync bits
		CDEF_DATA = 2'b11 // Timing taken, receiving data bits
	} cdef_state_t;

	// Five flag bits of one status register
	typedef logic [4:0] cdef_flags_t;

endpackage : cdef_pkg

// ### hdl/cdef_top.sv
// Debug error flag bank for serial and upper daisy-chain ports, APB slave
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`include "cdef_defs.svh"

module cdef_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial port transmit events
	input wire logic tx_busy,
	input wire logic uart_clear,
	input wire logic uart_frame_start,
	input wire logic tx_abort,
	// Serial port response receive events
	input wire logic resp_rx_busy,
	input wire logic resp_byte_err,
	input wire logic resp_crc_err,
	output logic resp_discard,
	output logic resp_ignore,
	// Upper chain port receive events
	input wire logic up_frame_start,
	input wire logic up_sync_ok,
	input wire logic up_sync_fail,
	input wire logic up_data_fail,
	input wire logic up_weak_bit,
	input wire logic up_tag_valid,
	input wire logic up_tag_bit,
	input wire logic up_abnormal,
	input wire logic up_frame_end,
	// Forwarded frame tag
	output logic bad_frame_tag_bit,
	// Interrupt
	output logic irq
);

	// Flag registers and their next values
	// Flags clear only through the clear register; the flag words are read-only
	cdef_pkg::cdef_flags_t uart_reg; // Serial port error flags
	cdef_pkg::cdef_flags_t uart_next;
	cdef_pkg::cdef_flags_t upper_reg; // Upper-port bit error flags
	cdef_pkg::cdef_flags_t upper_next;
	cdef_pkg::cdef_flags_t uart_set; // New serial events this cycle
	cdef_pkg::cdef_flags_t upper_set; // New upper events this cycle
	cdef_pkg::cdef_flags_t uart_clr; // Software clear strobes
	cdef_pkg::cdef_flags_t upper_clr;

	// Frame tracker
	cdef_pkg::cdef_state_t state_reg;
	cdef_pkg::cdef_state_t state_next;

	// Response ignore window and discard pulse
	logic ignore_reg;
	logic ignore_next;
	logic discard_reg;
	logic discard_next;

	// Forwarded tag
	logic tag_reg;
	logic tag_next;

	// Interrupt status and mask
	logic [1:0] int_stat_reg;
	logic [1:0] int_stat_next;
	logic [1:0] int_mask_reg;
	logic [1:0] int_mask_next;

	// Bus slave state
	logic ack_reg; // High in the answering access cycle
	logic ack_next;
	logic [31:0] rdata_reg; // Captured read data
	logic [31:0] rdata_next;
	logic err_reg; // Unmapped address seen
	logic err_next;

	// Bus decode
	logic [11:0] idx; // Word index of the access
	logic access; // Access phase, first cycle
	logic wr_done; // Write completes this edge
	logic hit_uart;
	logic hit_upper;
	logic hit_stat;
	logic hit_mask;
	logic hit_clr;
	logic mapped;

	// Address decode
	always_comb begin
		idx = paddr[13:2];
		hit_uart = (idx == `CDEF_IDX_UART);
		hit_upper = (idx == `CDEF_IDX_UPPER);
		hit_stat = (idx == `CDEF_IDX_INT_STAT);
		hit_mask = (idx == `CDEF_IDX_INT_MASK);
		hit_clr = (idx == `CDEF_IDX_CLEAR);
		mapped = hit_uart | hit_upper | hit_stat | hit_mask | hit_clr;
		// First access cycle only; the answering cycle must not start a second one
		access = psel & penable & ~ack_reg;
		// Writes land in the answering cycle, while the master still holds the request
		wr_done = psel & penable & ack_reg & pwrite;
	end

	// Bus answer: one wait cycle, read data captured from flops
	// Capturing in the first access cycle keeps prdata straight off flip-flops
	always_comb begin
		ack_next = access;
		err_next = access & ~mapped;
		rdata_next = rdata_reg;
		if (access) begin
			// Unmapped and write-only locations read as zero
			rdata_next = 32'h0000_0000;
			if (!pwrite) begin
				if (hit_uart) begin
					rdata_next = {27'h0000000, uart_reg};
				end else if (hit_upper) begin
					rdata_next = {27'h0000000, upper_reg};
				end else if (hit_stat) begin
					rdata_next = {30'h00000000, int_stat_reg};
				end else if (hit_mask) begin
					rdata_next = {30'h00000000, int_mask_reg};
				end
			end
		end
	end

	// Bus registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= ack_next;
			err_reg <= err_next;
			rdata_reg <= rdata_next;
		end
	end

	// Bus outputs
	// Error is shown only together with ready, never on its own
	assign pready = ack_reg;
	assign pslverr = ack_reg & err_reg;
	assign prdata = rdata_reg;

	// Software clear strobes, one per flag
	// The clear register holds nothing itself and reads as zero
	always_comb begin
		uart_clr = 5'h00;
		upper_clr = 5'h00;
		if (wr_done && hit_clr) begin
			uart_clr = pwdata[`CDEF_CLR_UART_LSB +: 5];
			upper_clr = pwdata[`CDEF_CLR_UPPER_LSB +: 5];
		end
	end

	// Upper-port frame tracker
	// Sync failures only count while the preamble is searched,
	// data failures only once timing has been taken
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			cdef_pkg::CDEF_IDLE: begin
				// A new frame starts with preamble search
				if (up_frame_start) begin
					state_next = cdef_pkg::CDEF_SYNC;
				end
			end
			cdef_pkg::CDEF_SYNC: begin
				// Timing taken or frame abandoned
				if (up_sync_ok) begin
					state_next = cdef_pkg::CDEF_DATA;
				end else if (up_sync_fail || up_frame_end) begin
					state_next = cdef_pkg::CDEF_IDLE;
				end
			end
			cdef_pkg::CDEF_DATA: begin
				// Frame ends, or data lost after lock
				if (up_frame_end || up_data_fail) begin
					state_next = cdef_pkg::CDEF_IDLE;
				end
			end
			default: begin
				state_next = cdef_pkg::CDEF_IDLE;
			end
		endcase
	end

	// Upper-port event detection
	// Each dedicated flag also raises protocol error in the same cycle
	always_comb begin
		upper_set = 5'h00;
		// Weak data bit sample count
		upper_set[`CDEF_UP_WEAK] = up_weak_bit; // see [RL8]
		// Preamble or sync bit not found
		upper_set[`CDEF_UP_FIRST_SYNC_ERROR_FLAG] = (state_reg == cdef_pkg::CDEF_SYNC) & up_sync_fail; // see [RL7]
		// Locked on timing but no valid data
		upper_set[`CDEF_UP_SECOND_SYNC_ERROR_FLAG] = (state_reg == cdef_pkg::CDEF_DATA) & up_data_fail; // see [RL6]
		// Frame arrives already tagged bad
		upper_set[`CDEF_UP_TAG] = up_tag_valid & up_tag_bit; // see [RL5]
		// Unclassified abnormality, or any dedicated flag set now
		upper_set[`CDEF_UP_PROTOCOL_ERROR_FLAG] = up_abnormal | (|upper_set[3:0]); // see [RL3]
	end

	// Upper flags: sticky, set wins over software clear
	// Setting wins over a clear in the same cycle, so no event is lost
	always_comb begin
		upper_next = (upper_reg & ~upper_clr) | upper_set;
		// Protocol error stays set while any other flag stays set
		if (|upper_next[3:0]) begin
			upper_next[`CDEF_UP_PROTOCOL_ERROR_FLAG] = 1'b1; // see [RL2]
		end
		// Forwarded frames carry the tag exactly while protocol error is set
		tag_next = upper_next[`CDEF_UP_PROTOCOL_ERROR_FLAG]; // see [RL1] see [RL4]
	end

	// Serial port event detection
	// Transmit start errors need a busy transmitter; an idle port takes a clear freely
	always_comb begin
		uart_set = 5'h00;
		// Clear or new frame while response still going out
		uart_set[`CDEF_UART_TRANSMIT_FRAME_START_ERROR] = (uart_clear | uart_frame_start) & tx_busy; // see [RL9]
		// Transmission terminated, waiting
		uart_set[`CDEF_UART_TRANSMIT_ABORT_WAIT_FLAG] = tx_abort;
		// Clear received in the middle of a response frame
		uart_set[`CDEF_UART_RESPONSE_FRAME_START_ERROR] = uart_clear & resp_rx_busy;
		// Byte and CRC errors, not checked inside an ignored frame
		uart_set[`CDEF_UART_RR_BYTE] = resp_byte_err & ~ignore_reg; // see [RL10]
		uart_set[`CDEF_UART_RESPONSE_CRC_ERROR] = resp_crc_err & ~ignore_reg; // see [RL10]
	end

	// Serial flags, ignore window and discard pulse
	// Inside the window no byte error is seen, so a clear then ends it
	always_comb begin
		uart_next = (uart_reg & ~uart_clr) | uart_set;
		// After a byte error the rest is ignored until a clear
		ignore_next = ignore_reg;
		if (uart_clear) begin
			ignore_next = 1'b0;
		end
		if (uart_set[`CDEF_UART_RR_BYTE]) begin
			ignore_next = 1'b1;
		end
		// Flagged response frames count as discarded
		discard_next = uart_set[`CDEF_UART_RR_BYTE] | uart_set[`CDEF_UART_RESPONSE_CRC_ERROR]; // see [RL10]
	end

	// Interrupt status and mask
	// One summary bit per flag word; software reads the word for detail
	always_comb begin
		int_stat_next = int_stat_reg;
		int_mask_next = int_mask_reg;
		// Write one to clear status
		if (wr_done && hit_stat) begin
			int_stat_next = int_stat_reg & ~pwdata[1:0];
		end
		if (wr_done && hit_mask) begin
			int_mask_next = pwdata[1:0];
		end
		// New events win over a clear in the same cycle
		if (|uart_set) begin
			int_stat_next[`CDEF_INT_UART] = 1'b1;
		end
		if (|upper_set) begin
			int_stat_next[`CDEF_INT_UPPER] = 1'b1;
		end
	end

	// Flag, tracker and interrupt registers
	// All flags come out of reset clear and the tracker idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uart_reg <= `CDEF_FLAGS_RST;
			upper_reg <= `CDEF_FLAGS_RST;
			state_reg <= cdef_pkg::CDEF_IDLE;
			ignore_reg <= 1'b0;
			discard_reg <= 1'b0;
			tag_reg <= 1'b0;
			int_stat_reg <= `CDEF_INT_RST;
			int_mask_reg <= `CDEF_INT_RST;
		end else begin
			uart_reg <= uart_next;
			upper_reg <= upper_next;
			state_reg <= state_next;
			ignore_reg <= ignore_next;
			discard_reg <= discard_next;
			tag_reg <= tag_next;
			int_stat_reg <= int_stat_next;
			int_mask_reg <= int_mask_next;
		end
	end

	// Block outputs
	// Interrupt is a level, held while any unmasked summary bit is set
	assign resp_discard = discard_reg;
	assign resp_ignore = ignore_reg;
	assign bad_frame_tag_bit = tag_reg;
	assign irq = |(int_stat_reg & int_mask_reg);

endmodule : cdef_top

// ### bench/cdef_assertions.sv
// Concurrent property checker for the debug error flag bank
`timescale 1ns/10ps
module cdef_assertions (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Upper port events
	input wire logic up_sync_fail,
	input wire logic up_data_fail,
	input wire logic up_weak_bit,
	input wire logic up_tag_valid,
	input wire logic up_tag_bit,
	input wire logic up_abnormal,
	// Response receive events and results
	input wire logic resp_byte_err,
	input wire logic resp_crc_err,
	input wire logic resp_discard,
	input wire logic resp_ignore,
	input wire logic bad_frame_tag_bit
);
	logic cause_q; // Some tag cause was seen one edge ago

	// Remember any event that may raise the forwarded tag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_q <= 1'b0;
		end else begin
			cause_q <= up_abnormal | up_sync_fail | up_data_fail | up_weak_bit
				| (up_tag_valid & up_tag_bit);
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_RDY_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("ready not given after one wait state");
	AST_RDY_ONE: assert property (pready |=> !pready) else $error("ready held too long");
	AST_ERR_PAIR: assert property (pslverr |-> pready) else $error("error without ready");
	AST_ABN_TAG: assert property (up_abnormal |=> bad_frame_tag_bit)
		else $error("abnormal frame not tagged");
	AST_TAG_IN: assert property (up_tag_valid && up_tag_bit |=> bad_frame_tag_bit)
		else $error("incoming tag did not set protocol error");
	AST_WEAK: assert property (up_weak_bit |=> bad_frame_tag_bit)
		else $error("weak bit did not set protocol error");
	AST_NO_CAUSE: assert property ($rose(bad_frame_tag_bit) |-> cause_q)
		else $error("tag raised without a cause");
	AST_DISCARD: assert property (resp_crc_err && !resp_ignore |=> resp_discard)
		else $error("errored response not discarded");
	// A byte error inside an ignored frame is not seen, so only a fresh one opens the window
	AST_IGNORE: assert property (resp_byte_err && !resp_ignore |=> resp_ignore)
		else $error("byte error did not start ignoring");
endmodule : cdef_assertions

bind cdef_top cdef_assertions chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .up_sync_fail(up_sync_fail), .up_data_fail(up_data_fail),
	.up_weak_bit(up_weak_bit), .up_tag_valid(up_tag_valid), .up_tag_bit(up_tag_bit),
	.up_abnormal(up_abnormal), .resp_byte_err(resp_byte_err), .resp_crc_err(resp_crc_err),
	.resp_discard(resp_discard), .resp_ignore(resp_ignore),
	.bad_frame_tag_bit(bad_frame_tag_bit)
);

// ### bench/cdef_up_rx.sv
// Upper daisy-chain receiver model that plays one frame per request
`timescale 1ns/10ps
module cdef_up_rx (
	// Clock and request
	input wire logic pclk,
	input wire logic go,
	input wire logic [1:0] kind,
	// Receiver pulses
	output logic up_frame_start,
	output logic up_sync_ok,
	output logic up_sync_fail,
	output logic up_data_fail,
	output logic up_frame_end
);
	logic [1:0] step = 2'h0; // Frame phase, zero when idle

	// Kind 0 clean, 1 sync lost, 2 data lost after timing taken
	always @(posedge pclk) begin
		if (go || step != 2'h0) begin
			step <= step + 2'h1;
		end
		up_frame_start <= go && step == 2'h0;
		up_sync_ok <= step == 2'h1 && kind != 2'h1;
		up_sync_fail <= step == 2'h1 && kind == 2'h1;
		up_data_fail <= step == 2'h2 && kind == 2'h2;
		up_frame_end <= step == 2'h3 && kind == 2'h0;
	end
endmodule : cdef_up_rx

// ### bench/tb_cdef_top.sv
// Self-checking bench for the debug error flag bank
`timescale 1ns/10ps
`include "cdef_defs.svh"
module tb_cdef_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ign;
	logic go, fs, sok, sf, df, fe, disc, ignd, tag, irq;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed, eu, ea;
	logic [10:0] ev, v; // Event inputs driven by the bench
	logic [1:0] kind;
	int num_errors = 0;
	int checked = 0;
	logic [11:0] rg [5] = '{`CDEF_IDX_UART, `CDEF_IDX_UPPER, `CDEF_IDX_INT_STAT,
		`CDEF_IDX_INT_MASK, `CDEF_IDX_CLEAR};
	logic [10:0] tab [11] = '{11'h001, 11'h006, 11'h004, 11'h008, 11'h010, 11'h020,
		11'h010, 11'h240, 11'h080, 11'h500, 11'h600};

	cdef_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_busy(ev[10]), .uart_clear(ev[9]), .uart_frame_start(ev[8]),
		.tx_abort(ev[7]), .resp_rx_busy(ev[6]), .resp_byte_err(ev[5]), .resp_crc_err(ev[4]),
		.resp_discard(disc), .resp_ignore(ignd), .up_frame_start(fs), .up_sync_ok(sok),
		.up_sync_fail(sf), .up_data_fail(df), .up_weak_bit(ev[0]), .up_tag_valid(ev[2]),
		.up_tag_bit(ev[1]), .up_abnormal(ev[3]), .up_frame_end(fe),
		.bad_frame_tag_bit(tag), .irq(irq));
	cdef_up_rx far_u (.pclk(pclk), .go(go), .kind(kind), .up_frame_start(fs),
		.up_sync_ok(sok), .up_sync_fail(sf), .up_data_fail(df), .up_frame_end(fe));

	// Clock and watchdog
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		num_errors++;
		test_done();
	end

	// Pseudo-random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Compare and count
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	// One APB transfer, held until ready
	task apb(input logic w, input logic [11:0] i, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Read and compare
	task rdc(input string n, input logic [11:0] i, input logic [31:0] e);
		apb(1'b0, i, 32'h0);
		chk(n, rd, e);
	endtask : rdc

	// Verdict
	task test_done;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, go, ign} = 6'h00;
		{paddr, pwdata, ev, kind} = '0;
		seed = 32'h976e;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) rdc("reset", rg[i], 32'h0);
		rdc("unmapped", 12'h7ff, 32'h0);
		chk("slverr", er, 32'h1);
		seed = lfsr(seed);
		apb(1'b1, `CDEF_IDX_UPPER, seed);
		rdc("read_only", `CDEF_IDX_UPPER, 32'h0);
		apb(1'b1, `CDEF_IDX_INT_MASK, seed);
		rdc("mask", `CDEF_IDX_INT_MASK, seed & 32'h3);
		apb(1'b1, `CDEF_IDX_INT_MASK, 32'h3);
		// Three partner frames, then single event pulses
		for (int i = 0; i < 14; i++) begin
			if (i < 3) begin
				kind <= i[1:0];
				go <= 1'b1;
				@(posedge pclk) go <= 1'b0;
				repeat (6) @(posedge pclk);
				eu = (i == 0) ? 32'h0 : (i == 1) ? 32'h12 : 32'h14;
				ea = 32'h0;
			end else begin
				v = tab[i - 3];
				@(posedge pclk) ev <= v;
				@(posedge pclk) ev <= 11'h0;
				#1;
				eu = {v[3], v[2] & v[1], 2'b00, v[0]};
				if (eu != 0) eu = eu | 32'h10;
				ea = {(v[9] | v[8]) & v[10], v[7], v[9] & v[6], v[5] & !ign, v[4] & !ign};
				chk("discard", disc, (v[4] | v[5]) & !ign);
				// A detected byte error wins over a clear in the same cycle
				ign = (ign & !v[9]) | (v[5] & !ign);
				chk("ignore", ignd, ign);
			end
			chk("tag", tag, eu[4]);
			chk("irq", irq, {31'h0, (eu | ea) != 0});
			rdc("upper", `CDEF_IDX_UPPER, eu);
			rdc("uart", `CDEF_IDX_UART, ea);
			apb(1'b1, `CDEF_IDX_CLEAR, 32'h1f1f);
			apb(1'b1, `CDEF_IDX_INT_STAT, 32'h3);
			#1;
			chk("irq_clear", irq, 32'h0);
			chk("tag_clear", tag, 32'h0);
			$display("case %0d done", i);
		end
		test_done();
	end
endmodule : tb_cdef_top
